// ==== design/spa_port_align.sv ====
// Frame flywheel and conventional-mode serial port alignment logic
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "spa_defines.svh"
module spa_flywheel
#(
  parameter bit FIRST_IS_CHANGE = 1'b0
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic bitTick,
  input wire logic syncTick,
  input wire logic syncIn,
  input wire logic chan,
  input wire logic [8:0] frameLen,
  output logic [8:0] bitCnt,
  output logic synced,
  output logic align,
  output logic entry,
  output logic again,
  output logic recover
);
  logic syncHeld;
  logic syncPrev;
  logic [1:0] frames;
  wire syncNow = syncTick ? syncIn : syncHeld;
  wire hit = chan && syncNow && !syncPrev;
  wire lastBit = bitCnt >= frameLen - 9'h001;
  wire unexp = hit && (synced ? !lastBit : FIRST_IS_CHANGE);
  wire frameStart = bitTick && (hit || lastBit);
  wire [8:0] next_bitCnt = frameStart ? 9'h000 : bitCnt + 9'h001;
  wire cleanEnd = align && frameStart && !unexp
    && frames == 2'(`SPA_RECOVER_FRAMES - 1);
  assign entry = bitTick && unexp && !align;
  assign again = bitTick && hit && align;
  assign recover = cleanEnd;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      syncHeld <= 1'b0;
      syncPrev <= 1'b0;
      bitCnt <= 9'h000;
      synced <= 1'b0;
      align <= 1'b0;
      frames <= 2'h0;
    end
    else
    begin
      if (syncTick)
        syncHeld <= syncIn;
      if (bitTick)
      begin
        syncPrev <= syncNow;
        bitCnt <= next_bitCnt;
      end
      if (bitTick && hit)
        synced <= 1'b1;
      if (!chan)
        align <= 1'b0;
      else if (bitTick && unexp)
      begin
        align <= 1'b1;
        frames <= 2'h0;
      end
      else if (cleanEnd)
        align <= 1'b0;
      else if (align && frameStart)
        frames <= frames + 2'h1;
    end
  end
endmodule : spa_flywheel

module spa_port_align
  import spa_pkg::*;
#(
  parameter logic [4:0] PORT_ID = 5'h00
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxLineClock,
  input wire logic rxLineData,
  input wire logic rxFrameSync,
  input wire logic rxOutOfFrameIn,
  input wire logic txLineClock,
  input wire logic txFrameSync,
  input wire logic txClearToSendIn,
  output logic txLineData,
  output logic txLineDataOe,
  output logic rxBitValid,
  output logic rxBit,
  output logic [4:0] rxSlot,
  output logic rxFirstSlot,
  output logic rxMsgTerminate,
  output logic rxEndValid,
  output logic [1:0] rxEndCode,
  input wire logic txBitIn,
  output logic txBitTake,
  output logic [4:0] txSlot,
  output logic txClearToSend,
  output logic txChannelsDown,
  output logic txAbortPulse,
  output logic descValid,
  output logic [2:0] descCode,
  output logic descDir,
  output logic [4:0] descPort,
  output logic generalPortIrq
);
  function automatic logic [8:0] frameBits(input logic [31:0] c);
    logic [5:0] slots;
    slots = {1'b0, 5'(c[`SPA_F_END +: 5] - c[`SPA_F_START +: 5])} + 6'h01;
    if (c[`SPA_F_KIND +: 2] == SPA_K_UNCHAN)
      return 9'(`SPA_BITS_PER_SLOT);
    return {slots, 3'h0} + {8'h00, c[`SPA_F_KIND +: 2] == SPA_K_T1};
  endfunction : frameBits

  function automatic logic [4:0] slotOf(input logic [31:0] c, input logic [8:0] b);
    logic [8:0] d;
    d = b - {8'h00, c[`SPA_F_KIND +: 2] == SPA_K_T1};
    return c[`SPA_F_START +: 5] + d[7:3];
  endfunction : slotOf

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction : merge

  function automatic spa_desc_t codeOf(input logic [6:0] g);
    if (g[0] || g[2])
      return SPA_D_ALIGN_CHANGE;
    if (g[1] || g[3])
      return SPA_D_ALIGN_RECOVERY;
    if (g[4])
      return SPA_D_OUT_OF_FRAME;
    if (g[5])
      return SPA_D_FRAME_RECOVERY;
    return SPA_D_GENERAL_PORT;
  endfunction : codeOf

  // Pin synchroniser: bit 0 rx clock .. bit 6 clear-to-send
  logic [6:0] s1;
  logic [6:0] s2;
  logic [6:0] s3;
  logic [6:0] lvl;
  logic [6:0] prev;
  wire [6:0] pins = {txClearToSendIn, txFrameSync, txLineClock, rxOutOfFrameIn,
    rxFrameSync, rxLineData, rxLineClock};
  wire [6:0] next_lvl = (s2 & s3) | (lvl & (s2 | s3));
  wire rxRise = lvl[0] && !prev[0];
  wire rxFall = !lvl[0] && prev[0];
  wire txRise = lvl[4] && !prev[4];
  wire txFall = !lvl[4] && prev[4];

  logic [31:0] rxCfg;
  logic [31:0] txCfg;
  wire rxChan = rxCfg[`SPA_F_KIND +: 2] != SPA_K_UNCHAN;
  wire txChan = txCfg[`SPA_F_KIND +: 2] != SPA_K_UNCHAN;
  wire txT1 = txCfg[`SPA_F_KIND +: 2] == SPA_K_T1;
  wire rxAbort = rxCfg[`SPA_F_ABORT];
  wire oofIrqEn = rxCfg[`SPA_F_GATE];
  // Edge select bit 1 picks rising, 0 falling
  wire rxDataTick = rxCfg[`SPA_F_DEDGE] ? rxRise : rxFall;
  wire rxSyncTick = rxCfg[`SPA_F_SEDGE] ? rxRise : rxFall;
  wire rxOofTick = rxCfg[`SPA_F_XEDGE] ? rxRise : rxFall;
  wire txDataTick = txCfg[`SPA_F_DEDGE] ? txRise : txFall;
  wire txSyncTick = txCfg[`SPA_F_SEDGE] ? txRise : txFall;
  wire ctsTick = txCfg[`SPA_F_XEDGE] ? txRise : txFall;

  logic [8:0] rxBitCnt;
  logic [8:0] txBitCnt;
  logic rxSynced;
  logic txSynced;
  logic rxAlign;
  logic txAlign;
  logic rxEntry;
  logic txEntry;
  logic rxAgain;
  logic txAgain;
  logic rxRecover;
  logic txRecover;

  spa_flywheel #(.FIRST_IS_CHANGE(1'b1)) u_rxFly (
    .clock(clock),
    .rst(rst),
    .bitTick(rxDataTick),
    .syncTick(rxSyncTick),
    .syncIn(lvl[2]),
    .chan(rxChan),
    .frameLen(frameBits(rxCfg)),
    .bitCnt(rxBitCnt),
    .synced(rxSynced),
    .align(rxAlign),
    .entry(rxEntry),
    .again(rxAgain),
    .recover(rxRecover)
  );

  spa_flywheel #(.FIRST_IS_CHANGE(1'b0)) u_txFly (
    .clock(clock),
    .rst(rst),
    .bitTick(txDataTick),
    .syncTick(txSyncTick),
    .syncIn(lvl[5]),
    .chan(txChan),
    .frameLen(frameBits(txCfg)),
    .bitCnt(txBitCnt),
    .synced(txSynced),
    .align(txAlign),
    .entry(txEntry),
    .again(txAgain),
    .recover(txRecover)
  );

  // Out-of-frame level and its delayed reporting
  logic oofState;
  logic oofPrev;
  logic ctsState;
  logic [3:0] oofWait;
  logic [3:0] regainWait;
  wire oofRise = oofState && !oofPrev;
  wire oofFall = !oofState && oofPrev;
  wire [3:0] slotWait = 4'(`SPA_BITS_PER_SLOT * `SPA_OOF_DELAY_SLOTS);
  wire oofDue = rxDataTick && oofWait == 4'h1;
  wire regainDue = rxDataTick && regainWait == 4'h1;
  wire gpSet = oofFall && !rxAbort && oofIrqEn;

  // Descriptor queue: one pending bit per event, lowest index first
  logic [6:0] pend;
  wire rxIrqEn = rxCfg[`SPA_F_IRQEN];
  wire txIrqEn = txCfg[`SPA_F_IRQEN];
  wire [6:0] setEv = {gpSet, regainDue, oofDue, txRecover && txIrqEn,
    (txEntry || txAgain) && txIrqEn, rxRecover && rxIrqEn,
    (rxEntry || rxAgain) && rxIrqEn};
  wire [6:0] grant = pend & (~pend + 7'h01);
  wire [6:0] next_pend = (pend & ~grant) | setEv;

  // Register bus
  logic awFull;
  logic wFull;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  wire doWrite = awFull && wFull && !bvalid;
  wire next_awFull = !doWrite && (awFull || (awvalid && awready));
  wire next_wFull = !doWrite && (wFull || (wvalid && wready));
  wire wrRx = doWrite && awAddrQ == `SPA_RX_CFG;
  wire wrTx = doWrite && awAddrQ == `SPA_TX_CFG;
  wire wrCmd = doWrite && awAddrQ == `SPA_CMD && wStrbQ[0] && wDataQ[0];
  wire wrMapped = wrRx || wrTx || wrCmd || awAddrQ == `SPA_STATUS
    || awAddrQ == `SPA_COUNT || awAddrQ == `SPA_CMD;
  wire rdTake = arvalid && arready;
  wire [31:0] statusWord = {23'h000000, txChannelsDown, generalPortIrq, ctsState,
    oofState, txSynced, rxSynced, txAlign, rxAlign};
  wire rdMapped = araddr == `SPA_RX_CFG || araddr == `SPA_TX_CFG
    || araddr == `SPA_STATUS || araddr == `SPA_COUNT;
  wire [31:0] rdWord = araddr == `SPA_RX_CFG ? rxCfg
    : araddr == `SPA_TX_CFG ? txCfg
    : araddr == `SPA_STATUS ? statusWord
    : araddr == `SPA_COUNT ? {7'h00, txBitCnt, 7'h00, rxBitCnt} : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awFull <= 1'b0;
      wFull <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end
    else
    begin
      awFull <= next_awFull;
      wFull <= next_wFull;
      awready <= !next_awFull;
      wready <= !next_wFull;
      if (awvalid && awready)
        awAddrQ <= awaddr;
      if (wvalid && wready)
      begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp <= wrMapped ? 2'h0 : 2'h2;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end
    else
    begin
      arready <= !(rvalid || rdTake) || (rvalid && rready);
      if (rdTake)
      begin
        rvalid <= 1'b1;
        rdata <= rdWord;
        rresp <= rdMapped ? 2'h0 : 2'h2;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rxCfg <= `SPA_CFG_RST;
      txCfg <= `SPA_CFG_RST;
    end
    else
    begin
      if (wrRx)
        rxCfg <= merge(rxCfg, wDataQ, wStrbQ);
      if (wrTx)
        txCfg <= merge(txCfg, wDataQ, wStrbQ);
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1 <= 7'h00;
      s2 <= 7'h00;
      s3 <= 7'h00;
      lvl <= 7'h00;
      prev <= 7'h00;
    end
    else
    begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
      prev <= lvl;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      oofState <= 1'b0;
      oofPrev <= 1'b0;
      ctsState <= 1'b0;
      oofWait <= 4'h0;
      regainWait <= 4'h0;
      generalPortIrq <= 1'b0;
    end
    else
    begin
      if (rxOofTick)
        oofState <= lvl[3];
      oofPrev <= oofState;
      if (ctsTick)
        ctsState <= lvl[6];
      if (oofRise && oofIrqEn)
        oofWait <= slotWait;
      else if (rxDataTick && oofWait != 4'h0)
        oofWait <= oofWait - 4'h1;
      if (oofFall && oofIrqEn)
        regainWait <= slotWait;
      else if (rxDataTick && regainWait != 4'h0)
        regainWait <= regainWait - 4'h1;
      if (gpSet)
        generalPortIrq <= 1'b1;
      else if (oofRise)
        generalPortIrq <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pend <= 7'h00;
      descValid <= 1'b0;
      descCode <= SPA_D_NONE;
      descDir <= 1'b0;
      descPort <= 5'h00;
    end
    else
    begin
      pend <= next_pend;
      descValid <= |pend;
      descCode <= |pend ? codeOf(grant) : SPA_D_NONE;
      descDir <= grant[2] || grant[3];
      descPort <= PORT_ID;
    end
  end

  // Receive side toward the line processor
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rxBitValid <= 1'b0;
      rxBit <= 1'b0;
      rxSlot <= 5'h00;
      rxFirstSlot <= 1'b0;
      rxMsgTerminate <= 1'b0;
      rxEndValid <= 1'b0;
      rxEndCode <= SPA_END_NONE;
    end
    else
    begin
      rxMsgTerminate <= rxAlign || (oofState && rxAbort);
      rxBitValid <= rxDataTick && !rxAlign && !(oofState && rxAbort);
      if (rxDataTick)
      begin
        rxBit <= (oofState && rxCfg[`SPA_F_TRANSP]) || lvl[1];
        rxSlot <= slotOf(rxCfg, rxBitCnt);
        rxFirstSlot <= slotOf(rxCfg, rxBitCnt) == rxCfg[`SPA_F_START +: 5];
      end
      rxEndValid <= rxEntry || (oofRise && !rxCfg[`SPA_F_TRANSP]);
      rxEndCode <= rxEntry ? SPA_END_ALIGN : (oofRise ? SPA_END_OOF : SPA_END_NONE);
    end
  end

  // Transmit side toward the pin and the buffer controller
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      txLineData <= 1'b0;
      txLineDataOe <= 1'b0;
      txBitTake <= 1'b0;
      txSlot <= 5'h00;
      txClearToSend <= 1'b1;
      txChannelsDown <= 1'b0;
      txAbortPulse <= 1'b0;
    end
    else
    begin
      txBitTake <= txDataTick;
      if (txDataTick)
      begin
        txLineData <= txBitIn;
        txLineDataOe <= !txAlign || (txT1 && txBitCnt == 9'h000);
        txSlot <= slotOf(txCfg, txBitCnt);
      end
      txClearToSend <= !txCfg[`SPA_F_GATE] || ctsState;
      txAbortPulse <= txEntry;
      if (txEntry)
        txChannelsDown <= 1'b1;
      else if (wrCmd && !txAlign)
        txChannelsDown <= 1'b0;
    end
  end

  property p_unchan;
    @(posedge clock) disable iff (rst) !rxChan |=> !rxAlign;
  endproperty
  a_unchan: assert property (p_unchan) else $error("align change in unchannelized mode");

  property p_rxEnd;
    @(posedge clock) disable iff (rst) rxEntry |=> rxEndValid && rxEndCode == SPA_END_ALIGN;
  endproperty
  a_rxEnd: assert property (p_rxEnd) else $error("no alignment end status");

  property p_chgDesc;
    @(posedge clock) disable iff (rst)
      rxEntry && rxIrqEn |-> ##[1:8] descValid && descCode == SPA_D_ALIGN_CHANGE && !descDir;
  endproperty
  a_chgDesc: assert property (p_chgDesc) else $error("alignment change not reported");

  property p_oofDesc;
    @(posedge clock) disable iff (rst)
      oofRise && oofIrqEn |-> ##[1:600] descValid && descCode == SPA_D_OUT_OF_FRAME;
  endproperty
  a_oofDesc: assert property (p_oofDesc) else $error("out-of-frame not reported");

  property p_abort;
    @(posedge clock) disable iff (rst) oofState && rxAbort |=> rxMsgTerminate && !rxBitValid;
  endproperty
  a_abort: assert property (p_abort) else $error("reception not stopped");

  property p_gp;
    @(posedge clock) disable iff (rst) gpSet |=> generalPortIrq ##1 generalPortIrq;
  endproperty
  a_gp: assert property (p_gp) else $error("general port interrupt missing");

  property p_tri;
    @(posedge clock) disable iff (rst)
      txDataTick && txAlign && !txT1 |=> !txLineDataOe;
  endproperty
  a_tri: assert property (p_tri) else $error("tx data driven during align change");

  property p_txDown;
    @(posedge clock) disable iff (rst) txEntry |=> txAbortPulse && txChannelsDown;
  endproperty
  a_txDown: assert property (p_txDown) else $error("tx channels not taken down");

  property p_cts;
    @(posedge clock) disable iff (rst)
      txCfg[`SPA_F_GATE] && !ctsState |=> !txClearToSend;
  endproperty
  a_cts: assert property (p_cts) else $error("clear-to-send gate ignored");
endmodule : spa_port_align
`default_nettype wire

// ==== design/spa_defines.svh ====
// Register map, field positions, reset values and counts of the port alignment block
`ifndef SPA_DEFINES_SVH
`define SPA_DEFINES_SVH
`define SPA_RX_CFG 8'h00
`define SPA_TX_CFG 8'h04
`define SPA_STATUS 8'h08
`define SPA_COUNT 8'h0c
`define SPA_CMD 8'h10
`define SPA_F_KIND 0
`define SPA_F_START 2
`define SPA_F_END 7
`define SPA_F_IRQEN 12
`define SPA_F_DEDGE 13
`define SPA_F_SEDGE 14
`define SPA_F_XEDGE 15
`define SPA_F_GATE 16
`define SPA_F_ABORT 17
`define SPA_F_TRANSP 18
`define SPA_CFG_RST 32'h0000_0f80
`define SPA_BITS_PER_SLOT 8
`define SPA_OOF_DELAY_SLOTS 1
`define SPA_RECOVER_FRAMES 2
`endif

// ==== design/spa_pkg.sv ====
// Types shared by the port alignment block
package spa_pkg;
  typedef enum logic [1:0] {SPA_K_CHAN = 2'h0, SPA_K_UNCHAN = 2'h1, SPA_K_T1 = 2'h2} spa_kind_t;
  typedef enum logic [2:0] {
    SPA_D_NONE = 3'h0,
    SPA_D_ALIGN_CHANGE = 3'h1,
    SPA_D_ALIGN_RECOVERY = 3'h2,
    SPA_D_OUT_OF_FRAME = 3'h3,
    SPA_D_FRAME_RECOVERY = 3'h4,
    SPA_D_GENERAL_PORT = 3'h5
  } spa_desc_t;
  typedef enum logic [1:0] {SPA_END_NONE = 2'h0, SPA_END_ALIGN = 2'h1, SPA_END_OOF = 2'h2} spa_end_t;
endpackage : spa_pkg

// ==== verif/spa_framer_model.sv ====
// Behavioural framer that drives the line pins of one port
`timescale 1ns/1ps
`default_nettype none
module spa_framer_model
(
  input wire logic oofReq,
  input wire logic ctsReq,
  output logic rxLineClock,
  output logic rxLineData,
  output logic rxFrameSync,
  output logic rxOutOfFrameIn,
  output logic txLineClock,
  output logic txFrameSync,
  output logic txClearToSendIn
);
  logic [2:0] pat;
  initial
  begin
    pat = 3'h0;
    rxLineData = 1'b0;
    rxFrameSync = 1'b0;
    rxOutOfFrameIn = 1'b0;
    txFrameSync = 1'b0;
    txClearToSendIn = 1'b1;
    rxLineClock = 1'b0;
    forever #100 rxLineClock = ~rxLineClock;
  end
  // Tx clock free-runs at the same rate but an unrelated phase
  initial
  begin
    txLineClock = 1'b0;
    #37;
    forever #100 txLineClock = ~txLineClock;
  end
  // Launch on the rising edge so the falling-edge sampling sees settled pins
  always @(posedge rxLineClock)
  begin
    pat <= pat + 3'h1;
    rxLineData <= pat[0] ^ pat[2];
    rxOutOfFrameIn <= oofReq;
  end
  always @(posedge txLineClock)
    txClearToSendIn <= ctsReq;
  // One-bit frame sync after skip further line bits
  task send_sync(input logic tx, input int skip);
    if (tx)
    begin
      repeat (skip + 1) @(posedge txLineClock);
      txFrameSync <= 1'b1;
      @(posedge txLineClock);
      txFrameSync <= 1'b0;
    end
    else
    begin
      repeat (skip + 1) @(posedge rxLineClock);
      rxFrameSync <= 1'b1;
      @(posedge rxLineClock);
      rxFrameSync <= 1'b0;
    end
  endtask : send_sync
endmodule : spa_framer_model
`default_nettype wire

// ==== verif/test_serial_port_frame_alignment.sv ====
// Self-checking bench of the serial port frame alignment block
`timescale 1ns/1ps
`default_nettype none
`include "spa_defines.svh"
module test_serial_port_frame_alignment
  import spa_pkg::*;
;
  localparam logic [4:0] PORT = 5'h03;
  localparam int LIMIT = 12000;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic [1:0] s;} spa_row_t;
  logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rxLineClock, rxLineData, rxFrameSync;
  logic rxOutOfFrameIn, txLineClock, txFrameSync, txClearToSendIn, txLineData;
  logic txLineDataOe, rxBitValid, rxBit, rxFirstSlot, rxMsgTerminate, rxEndValid;
  logic txBitIn, txBitTake, txClearToSend, txChannelsDown, txAbortPulse, descValid;
  logic descDir, generalPortIrq, oofReq, ctsReq, sawAbort;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rxEndCode, lastEnd, rs;
  logic [4:0] rxSlot, txSlot, descPort;
  logic [2:0] descCode;
  logic [8:0] descQ[$];
  int fail_count, total_checks, cyc, t0, rxBits, nb;
  spa_row_t rows[5] = '{'{8'h00, 32'h0007_ffff, 32'h0007_ffff, 2'h0},
    '{8'h04, 32'h0001_ffff, 32'h0001_ffff, 2'h0}, '{8'h20, 32'hffff_ffff, 32'h0, 2'h2},
    '{8'h00, 32'h0000_0f80, 32'h0000_0f80, 2'h0}, '{8'h04, 32'h0000_0f80, 32'h0000_0f80, 2'h0}};

  spa_port_align #(.PORT_ID(PORT)) DUT (.clock, .rst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .rxLineClock, .rxLineData, .rxFrameSync, .rxOutOfFrameIn,
    .txLineClock, .txFrameSync, .txClearToSendIn, .txLineData, .txLineDataOe, .rxBitValid,
    .rxBit, .rxSlot, .rxFirstSlot, .rxMsgTerminate, .rxEndValid, .rxEndCode, .txBitIn,
    .txBitTake, .txSlot, .txClearToSend, .txChannelsDown, .txAbortPulse, .descValid,
    .descCode, .descDir, .descPort, .generalPortIrq);
  spa_framer_model u_framer (.oofReq, .ctsReq, .rxLineClock, .rxLineData, .rxFrameSync,
    .rxOutOfFrameIn, .txLineClock, .txFrameSync, .txClearToSendIn);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Event capture, tx bit supply and hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (descValid === 1'b1) descQ.push_back({descPort, descDir, descCode});
    if (rxEndValid === 1'b1) lastEnd <= rxEndCode;
    if (txAbortPulse === 1'b1) sawAbort <= 1'b1;
    if (txBitTake === 1'b1) txBitIn <= ~txBitIn;
    if (rxBitValid === 1'b1) rxBits <= rxBits + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      wrap_up();
    end
  end

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    s = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task wait_desc(input logic dir, input logic [2:0] code);
    int n;
    logic [8:0] d;
    n = 0;
    while (descQ.size() == 0 && n < 500)
    begin
      @(posedge clock);
      n++;
    end
    d = (descQ.size() > 0) ? descQ.pop_front() : 9'bx;
    chk_val({23'h0, d}, {23'h0, PORT, dir, code});
  endtask : wait_desc

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, txBitIn, oofReq, sawAbort} = 8'h00;
    ctsReq = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    lastEnd = 2'h0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk_val({31'h0, txClearToSend}, 32'h1);
    chk_val({31'h0, generalPortIrq}, 32'h0);
    axi_read(`SPA_RX_CFG, rd, rs);
    chk_val(rd, 32'h0000_0f80);
    axi_read(`SPA_TX_CFG, rd, rs);
    chk_val(rd, 32'h0000_0f80);
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      axi_write(rows[i].a, rows[i].d, rs);
      chk_val({30'h0, rs}, {30'h0, rows[i].s});
      axi_read(rows[i].a, rd, rs);
      chk_val(rd, rows[i].r);
      chk_val({30'h0, rs}, {30'h0, rows[i].s});
    end
    $display("test register rows done");
    axi_write(`SPA_RX_CFG, 32'h0000_1001, rs);
    u_framer.send_sync(1'b0, 0);
    repeat (200) @(posedge clock);
    chk_val(descQ.size(), 0);
    $display("test unchannelized done");
    axi_write(`SPA_RX_CFG, 32'h0001_1000, rs);
    u_framer.send_sync(1'b0, 0);
    wait_desc(1'b0, SPA_D_ALIGN_CHANGE);
    t0 = cyc;
    nb = rxBits;
    repeat (4) @(posedge clock);
    chk_val({31'h0, rxMsgTerminate}, 32'h1);
    chk_val({30'h0, lastEnd}, {30'h0, SPA_END_ALIGN});
    wait_desc(1'b0, SPA_D_ALIGN_RECOVERY);
    chk_val({31'h0, (cyc - t0 >= 120)}, 32'h1);
    chk_val(rxBits, nb);
    chk_val({27'h0, rxSlot}, 32'h0);
    chk_val({31'h0, rxFirstSlot}, 32'h1);
    repeat (4) @(posedge clock);
    chk_val({31'h0, rxMsgTerminate}, 32'h0);
    $display("test rx alignment done");
    oofReq <= 1'b1;
    wait_desc(1'b0, SPA_D_OUT_OF_FRAME);
    repeat (4) @(posedge clock);
    chk_val({30'h0, lastEnd}, {30'h0, SPA_END_OOF});
    chk_val({31'h0, rxMsgTerminate}, 32'h0);
    chk_val({31'h0, rxBits > nb}, 32'h1);
    oofReq <= 1'b0;
    wait_desc(1'b0, SPA_D_GENERAL_PORT);
    wait_desc(1'b0, SPA_D_FRAME_RECOVERY);
    repeat (4) @(posedge clock);
    chk_val({31'h0, generalPortIrq}, 32'h1);
    oofReq <= 1'b1;
    wait_desc(1'b0, SPA_D_OUT_OF_FRAME);
    repeat (4) @(posedge clock);
    chk_val({31'h0, generalPortIrq}, 32'h0);
    axi_write(`SPA_RX_CFG, 32'h0003_1000, rs);
    repeat (16) @(posedge clock);
    chk_val({31'h0, rxMsgTerminate}, 32'h1);
    nb = rxBits;
    repeat (16) @(posedge clock);
    chk_val(rxBits, nb);
    oofReq <= 1'b0;
    wait_desc(1'b0, SPA_D_FRAME_RECOVERY);
    repeat (4) @(posedge clock);
    chk_val({31'h0, rxMsgTerminate}, 32'h0);
    chk_val({31'h0, rxBits > nb}, 32'h1);
    chk_val({31'h0, generalPortIrq}, 32'h0);
    $display("test out of frame done");
    axi_write(`SPA_TX_CFG, 32'h0000_1000, rs);
    u_framer.send_sync(1'b1, 0);
    repeat (80) @(posedge clock);
    chk_val(descQ.size(), 0);
    u_framer.send_sync(1'b1, 3);
    wait_desc(1'b1, SPA_D_ALIGN_CHANGE);
    repeat (16) @(posedge clock);
    chk_val({31'h0, sawAbort}, 32'h1);
    chk_val({31'h0, txChannelsDown}, 32'h1);
    chk_val({31'h0, txLineDataOe}, 32'h0);
    u_framer.send_sync(1'b1, 0);
    wait_desc(1'b1, SPA_D_ALIGN_CHANGE);
    wait_desc(1'b1, SPA_D_ALIGN_RECOVERY);
    axi_write(`SPA_CMD, 32'h0000_0001, rs);
    repeat (2) @(posedge clock);
    chk_val({31'h0, txChannelsDown}, 32'h0);
    $display("test tx alignment done");
    axi_write(`SPA_TX_CFG, 32'h0001_1000, rs);
    ctsReq <= 1'b0;
    repeat (40) @(posedge clock);
    chk_val({31'h0, txClearToSend}, 32'h0);
    ctsReq <= 1'b1;
    repeat (40) @(posedge clock);
    chk_val({31'h0, txClearToSend}, 32'h1);
    $display("test clear to send done");
    wrap_up();
  end
endmodule : test_serial_port_frame_alignment
`default_nettype wire
